//--- crcfs_pkg.sv
// ****************************************************************
// Register map, field layout and reset values
// ****************************************************************
package crcfs_pkg;
    // Byte offsets on the register bus.
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_POLYNOMIAL_LENGTH = 8'h04;
    localparam logic [7:0] ADDR_POLY = 8'h08;
    localparam logic [7:0] ADDR_DATA = 8'h0C;
    localparam logic [7:0] ADDR_RESULT = 8'h10;
    localparam logic [7:0] ADDR_INT_STAT = 8'h14;
    localparam logic [7:0] ADDR_INT_MASK = 8'h18;

    // Field positions inside the low control register.
    localparam int STOP_IDLE_BIT = 13;
    localparam int VALID_WORD_POINTER_LSB = 8;
    localparam int VALID_WORD_POINTER_W = 5;
    localparam int FULL_BIT = 7;
    localparam int EMPTY_BIT = 6;
    localparam int ISEL_BIT = 5;
    localparam int GO_BIT = 4;
    localparam int LEND_BIT = 3;

    // Field positions inside the interrupt status and mask registers.
    localparam int INT_EMPTY_BIT = 0;
    localparam int INT_DONE_BIT = 1;
    localparam int INT_W = 2;

    // Polynomial length field width and FIFO capacity limits.
    localparam int POLYNOMIAL_LENGTH_W = 5;
    localparam logic [4:0] POLYNOMIAL_LENGTH_SPLIT = 5'h07;
    localparam logic [4:0] DEPTH_SHORT = 5'h08;
    localparam int DEPTH_LONG = 16;
    localparam int DATA_W_DEF = 16;

    // Reset values.
    localparam logic [4:0] POLYNOMIAL_LENGTH_RST = 5'h0F;
    localparam logic [31:0] POLY_RST = 32'h0000_0000;
    localparam logic [31:0] RESULT_RST = 32'h0000_0000;
    localparam logic [1:0] INT_MASK_RST = 2'h0;

    // Shifter states.
    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_SHIFT = 2'b10
    } crcfs_state_t;
endpackage : crcfs_pkg

//--- crcfs_step.sv
`timescale 1ns/10ps
// ****************************************************************
// One serial step of a programmable-length CRC register
// ****************************************************************
module crcfs_step #(
    parameter int W = 32
) (
    input wire logic [W-1:0] crc_in,
    input wire logic [W-1:0] poly_in,
    input wire logic [4:0] polynomial_length_in,
    input wire logic din_in,
    output logic [W-1:0] crc_out
);
    logic [W-1:0] len_mask;
    logic [W-1:0] shifted;
    logic feedback;

    // Feedback is the top bit of the active length mixed with the data bit.
    always_comb begin
        len_mask = '0;
        for (int i = 0; i < W; i++) begin
            len_mask[i] = (i <= int'(polynomial_length_in));
        end
        feedback = crc_in[polynomial_length_in] ^ din_in;
        shifted = {crc_in[W-2:0], 1'b0};
        if (feedback) begin
            crc_out = (shifted ^ poly_in) & len_mask;
        end else begin
            crc_out = shifted & len_mask;
        end
    end
endmodule : crcfs_step

//--- crcfs_ctrl.sv
// Local design decisions: the Wishbone slave port and the register addresses.
`timescale 1ns/10ps
// Functional notes
// - Full flag set exactly while FIFO holds capacity or more.
// - Empty flag set exactly while FIFO holds nothing.
// - Interrupt source: FIFO empty or shift done.
// - Writing start one runs the serial shifter.
// - Start zero keeps the shifter stopped.
// - Direction one feeds each word LSb first.
// - Direction zero feeds each word MSb first.
// - Stop-in-idle halts the shifter in idle mode.
module crcfs_ctrl #(
    parameter int DATA_W = crcfs_pkg::DATA_W_DEF,
    parameter int FIFO_DEPTH = crcfs_pkg::DEPTH_LONG
) (
    input wire logic mclk_in,
    input wire logic sys_rst_in,
    input wire logic wb_cyc_in,
    input wire logic wb_stb_in,
    input wire logic wb_we_in,
    input wire logic [7:0] wb_adr_in,
    input wire logic [3:0] wb_sel_in,
    input wire logic [31:0] wb_dat_in,
    output logic [31:0] wb_dat_out,
    output logic wb_ack_out,
    input wire logic idle_mode_in,
    output logic irq_out
);
    localparam int AW = $clog2(FIFO_DEPTH);
    localparam logic [4:0] DEPTH_CAP = FIFO_DEPTH[4:0];
    localparam logic [4:0] LAST_BIT = 5'(DATA_W - 1);

    // ************************************************************
    // Parameter checks
    // ************************************************************
    // The pointer field is five bits wide and the pointers must wrap.
    if (DATA_W < 1 || DATA_W > 32) begin : g_bad_width
        $error("DATA_W must lie between 1 and 32");
    end
    if (FIFO_DEPTH <= 8 || FIFO_DEPTH > 16 ||
        (FIFO_DEPTH & (FIFO_DEPTH - 1)) != 0) begin : g_bad_depth
        $error("FIFO_DEPTH must be 16");
    end

    // ************************************************************
    // Declarations
    // ************************************************************
    logic stop_idle, next_stop_idle, isel, next_isel;
    logic go, next_go, lend, next_lend, next_irq, next_ack;
    logic [4:0] polynomial_length, next_polynomial_length, count, next_count;
    logic [4:0] bitcnt, next_bitcnt, cap;
    logic [31:0] poly, next_poly, crc, next_crc;
    logic [31:0] next_rdat, step_crc;
    logic [1:0] int_mask, next_int_mask, int_stat, next_int_stat;
    logic [DATA_W-1:0] mem [FIFO_DEPTH];
    logic [DATA_W-1:0] shreg, next_shreg;
    logic [AW-1:0] wptr, next_wptr, rptr, next_rptr;
    crcfs_pkg::crcfs_state_t state, next_state;
    logic req, acc, wr, rd, full, empty, push, pop, halt, run;
    logic ev_empty, ev_done, din;
    logic [15:0] ctrl_word;

    // Merges a bus write into a register under the byte enables.
    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] val,
                                          input logic [3:0] sel);
        logic [31:0] res;
        res = old;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                res[b*8 +: 8] = val[b*8 +: 8];
            end
        end
        return res;
    endfunction : merge

    // ************************************************************
    // Wishbone slave
    // ************************************************************
    // A request is answered one cycle after it appears; the write and
    // any read side effect happen on the edge where ack is high.
    assign req = wb_cyc_in & wb_stb_in;
    assign acc = req & wb_ack_out;
    assign wr = acc & wb_we_in;
    assign rd = acc & ~wb_we_in;

    // Read view of the low control register.
    always_comb begin
        ctrl_word = 16'h0000;
        ctrl_word[crcfs_pkg::STOP_IDLE_BIT] = stop_idle;
        ctrl_word[crcfs_pkg::VALID_WORD_POINTER_LSB +: crcfs_pkg::VALID_WORD_POINTER_W] = count;
        ctrl_word[crcfs_pkg::FULL_BIT] = full;
        ctrl_word[crcfs_pkg::EMPTY_BIT] = empty;
        ctrl_word[crcfs_pkg::ISEL_BIT] = isel;
        ctrl_word[crcfs_pkg::GO_BIT] = go;
        ctrl_word[crcfs_pkg::LEND_BIT] = lend;
    end

    // Ack answers every request; read data is loaded for reads only.
    always_comb begin
        next_ack = req & ~wb_ack_out;
        next_rdat = wb_dat_out;
        if (req & ~wb_ack_out & ~wb_we_in) begin
            case (wb_adr_in)
                crcfs_pkg::ADDR_CTRL: next_rdat = {16'h0000, ctrl_word};
                crcfs_pkg::ADDR_POLYNOMIAL_LENGTH: next_rdat = {27'h0, polynomial_length};
                crcfs_pkg::ADDR_POLY: next_rdat = poly;
                crcfs_pkg::ADDR_RESULT: next_rdat = crc;
                crcfs_pkg::ADDR_INT_STAT: next_rdat = {30'h0, next_int_stat};
                crcfs_pkg::ADDR_INT_MASK: next_rdat = {30'h0, int_mask};
                default: next_rdat = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge mclk_in) begin
        if (sys_rst_in) begin
            wb_ack_out <= 1'b0;
            wb_dat_out <= 32'h0000_0000;
        end else begin
            wb_ack_out <= next_ack;
            wb_dat_out <= next_rdat;
        end
    end

    // ************************************************************
    // Configuration registers
    // ************************************************************
    // Start is cleared by hardware at the end of shifting; a software
    // write of one in the same cycle wins.
    always_comb begin
        logic [31:0] m;
        m = 32'h0000_0000;
        next_stop_idle = stop_idle;
        next_isel = isel;
        next_go = go;
        next_lend = lend;
        next_polynomial_length = polynomial_length;
        next_poly = poly;
        next_int_mask = int_mask;
        if (ev_done) begin
            next_go = 1'b0;
        end
        if (wr) begin
            m = merge({16'h0000, ctrl_word}, wb_dat_in, wb_sel_in);
            case (wb_adr_in)
                crcfs_pkg::ADDR_CTRL: begin
                    next_stop_idle = m[crcfs_pkg::STOP_IDLE_BIT];
                    next_isel = m[crcfs_pkg::ISEL_BIT];
                    next_go = m[crcfs_pkg::GO_BIT];
                    next_lend = m[crcfs_pkg::LEND_BIT];
                end
                crcfs_pkg::ADDR_POLYNOMIAL_LENGTH: begin
                    m = merge({27'h0, polynomial_length}, wb_dat_in, wb_sel_in);
                    next_polynomial_length = m[crcfs_pkg::POLYNOMIAL_LENGTH_W-1:0];
                end
                crcfs_pkg::ADDR_POLY: next_poly = merge(poly, wb_dat_in,
                                                         wb_sel_in);
                crcfs_pkg::ADDR_INT_MASK: begin
                    m = merge({30'h0, int_mask}, wb_dat_in, wb_sel_in);
                    next_int_mask = m[crcfs_pkg::INT_W-1:0];
                end
                default: m = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge mclk_in) begin
        if (sys_rst_in) begin
            stop_idle <= 1'b0;
            isel <= 1'b0;
            go <= 1'b0;
            lend <= 1'b0;
            polynomial_length <= crcfs_pkg::POLYNOMIAL_LENGTH_RST;
            poly <= crcfs_pkg::POLY_RST;
            int_mask <= crcfs_pkg::INT_MASK_RST;
        end else begin
            stop_idle <= next_stop_idle;
            isel <= next_isel;
            go <= next_go;
            lend <= next_lend;
            polynomial_length <= next_polynomial_length;
            poly <= next_poly;
            int_mask <= next_int_mask;
        end
    end

    // ************************************************************
    // Input word FIFO
    // ************************************************************
    // Capacity shrinks to eight words for polynomials longer than 8 bits.
    assign cap = (polynomial_length > crcfs_pkg::POLYNOMIAL_LENGTH_SPLIT) ? crcfs_pkg::DEPTH_SHORT
                                                : DEPTH_CAP;
    assign full = (count >= cap);
    assign empty = (count == 5'h00);
    assign push = wr & (wb_adr_in == crcfs_pkg::ADDR_DATA) & ~full;
    assign pop = (state == crcfs_pkg::ST_IDLE) & run & ~empty;
    assign ev_empty = pop & (count == 5'h01) & ~push;

    // Pointers and word count; writes to a full FIFO are dropped.
    always_comb begin
        next_wptr = push ? wptr + 1'b1 : wptr;
        next_rptr = pop ? rptr + 1'b1 : rptr;
        next_count = count;
        case ({push, pop})
            2'b10: next_count = count + 5'h01;
            2'b01: next_count = count - 5'h01;
            default: next_count = count;
        endcase
    end

    always_ff @(posedge mclk_in) begin
        if (sys_rst_in) begin
            wptr <= '0;
            rptr <= '0;
            count <= 5'h00;
        end else begin
            wptr <= next_wptr;
            rptr <= next_rptr;
            count <= next_count;
        end
    end

    // Word storage needs no reset; only pushed words are ever read.
    always_ff @(posedge mclk_in) begin
        if (push) begin
            mem[wptr] <= wb_dat_in[DATA_W-1:0];
        end
    end

    // ************************************************************
    // Serial shifter
    // ************************************************************
    assign halt = stop_idle & idle_mode_in;
    assign run = go & ~halt;
    assign din = lend ? shreg[0] : shreg[DATA_W-1];

    crcfs_step #(
        .W(32)
    ) u_step (
        .crc_in(crc),
        .poly_in(poly),
        .polynomial_length_in(polynomial_length),
        .din_in(din),
        .crc_out(step_crc)
    );

    assign ev_done = (state == crcfs_pkg::ST_SHIFT) & run &
                     (bitcnt == LAST_BIT) & empty;

    // Idle pops a word when running; shift feeds one bit per cycle and
    // freezes while stopped or halted.
    always_comb begin
        next_state = state;
        next_shreg = shreg;
        next_bitcnt = bitcnt;
        next_crc = crc;
        case (state)
            crcfs_pkg::ST_IDLE: begin
                if (pop) begin
                    next_shreg = mem[rptr];
                    next_bitcnt = 5'h00;
                    next_state = crcfs_pkg::ST_SHIFT;
                end
            end
            crcfs_pkg::ST_SHIFT: begin
                if (run) begin
                    next_crc = step_crc;
                    next_bitcnt = bitcnt + 5'h01;
                    if (lend) begin
                        next_shreg = shreg >> 1;
                    end else begin
                        next_shreg = shreg << 1;
                    end
                    if (bitcnt == LAST_BIT) begin
                        next_state = crcfs_pkg::ST_IDLE;
                    end
                end
            end
            default: next_state = crcfs_pkg::ST_IDLE;
        endcase
        if (wr && wb_adr_in == crcfs_pkg::ADDR_RESULT) begin
            next_crc = merge(crc, wb_dat_in, wb_sel_in);
        end
    end

    always_ff @(posedge mclk_in) begin
        if (sys_rst_in) begin
            state <= crcfs_pkg::ST_IDLE;
            shreg <= '0;
            bitcnt <= 5'h00;
            crc <= crcfs_pkg::RESULT_RST;
        end else begin
            state <= next_state;
            shreg <= next_shreg;
            bitcnt <= next_bitcnt;
            crc <= next_crc;
        end
    end

    // ************************************************************
    // Interrupt
    // ************************************************************
    // Reading status clears it; an event in that same cycle survives.
    always_comb begin
        next_int_stat = int_stat;
        if (rd && wb_adr_in == crcfs_pkg::ADDR_INT_STAT) begin
            next_int_stat = 2'h0;
        end
        if (ev_empty) begin
            next_int_stat[crcfs_pkg::INT_EMPTY_BIT] = 1'b1;
        end
        if (ev_done) begin
            next_int_stat[crcfs_pkg::INT_DONE_BIT] = 1'b1;
        end
        if (isel) begin
            next_irq = next_int_stat[crcfs_pkg::INT_EMPTY_BIT] &
                       int_mask[crcfs_pkg::INT_EMPTY_BIT];
        end else begin
            next_irq = next_int_stat[crcfs_pkg::INT_DONE_BIT] &
                       int_mask[crcfs_pkg::INT_DONE_BIT];
        end
    end

    always_ff @(posedge mclk_in) begin
        if (sys_rst_in) begin
            int_stat <= 2'h0;
            irq_out <= 1'b0;
        end else begin
            int_stat <= next_int_stat;
            irq_out <= next_irq;
        end
    end
endmodule : crcfs_ctrl

//--- crcfs_ctrl_assertions.sv
`timescale 1ns/10ps
// ********************************************
// Port-level checks of the CRC control block
// ********************************************
module crcfs_ctrl_assertions (
    input wire logic mclk_in,
    input wire logic sys_rst_in,
    input wire logic wb_cyc_in,
    input wire logic wb_stb_in,
    input wire logic wb_we_in,
    input wire logic [7:0] wb_adr_in,
    input wire logic [3:0] wb_sel_in,
    input wire logic [31:0] wb_dat_in,
    input wire logic [31:0] wb_dat_out,
    input wire logic wb_ack_out,
    input wire logic idle_mode_in,
    input wire logic irq_out
);
    logic rd_ctrl;
    logic [4:0] ptr;

    // A control register read is being answered in this cycle.
    assign rd_ctrl = wb_ack_out && !wb_we_in &&
        (wb_adr_in == crcfs_pkg::ADDR_CTRL);
    assign ptr = wb_dat_out[12:8];

    default clocking cb @(posedge mclk_in);
    endclocking
    default disable iff (sys_rst_in);

    // Every request is answered after exactly one cycle.
    a_ack_one_cycle: assert property (wb_cyc_in && wb_stb_in && !wb_ack_out
        |=> wb_ack_out) else $error("ack late");
    a_ack_single_pulse: assert property (wb_ack_out |=> !wb_ack_out)
        else $error("ack longer than one cycle");
    a_rdata_hold: assert property (!(wb_ack_out && !wb_we_in)
        |-> $stable(wb_dat_out)) else $error("read data moved");
    a_unmapped_zero: assert property (wb_ack_out && !wb_we_in &&
        wb_adr_in > crcfs_pkg::ADDR_INT_MASK |-> wb_dat_out == 32'h0)
        else $error("unmapped read not zero");
    // Flag and pointer consistency in the control register view.
    a_flags_exclusive: assert property (rd_ctrl |-> !(wb_dat_out[7] &&
        wb_dat_out[6])) else $error("full and empty together");
    a_empty_ptr_zero: assert property (rd_ctrl |->
        wb_dat_out[6] == (ptr == 5'h00)) else $error("empty flag wrong");
    a_full_at_cap: assert property (rd_ctrl && wb_dat_out[7] |->
        ptr == 5'h08 || ptr == 5'h10) else $error("full off capacity");
    a_ptr_bound: assert property (rd_ctrl |-> ptr <= 5'h10 &&
        (ptr != 5'h10 || wb_dat_out[7])) else $error("pointer overflow");
    a_low_bits_zero: assert property (rd_ctrl |->
        wb_dat_out[2:0] == 3'h0) else $error("reserved bits set");
endmodule : crcfs_ctrl_assertions

bind crcfs_ctrl crcfs_ctrl_assertions u_chk (.mclk_in(mclk_in),
    .sys_rst_in(sys_rst_in), .wb_cyc_in(wb_cyc_in), .wb_stb_in(wb_stb_in),
    .wb_we_in(wb_we_in), .wb_adr_in(wb_adr_in), .wb_sel_in(wb_sel_in),
    .wb_dat_in(wb_dat_in), .wb_dat_out(wb_dat_out),
    .wb_ack_out(wb_ack_out), .idle_mode_in(idle_mode_in),
    .irq_out(irq_out));

//--- tb_crcfs_ctrl.sv
`timescale 1ns/10ps
`define CHK(nm, e, g) begin \
    checks_done++; \
    if ((g) !== (e)) begin \
        errors++; \
        $display("MISMATCH %s exp %h got %h", nm, e, g); \
    end \
end
// ********************************************
// Self-checking bench of the CRC control block
// ********************************************
module tb_crcfs_ctrl;
    logic mclk_in = 1'b0;
    logic sys_rst_in = 1'b1;
    logic wb_cyc = 1'b0;
    logic wb_stb = 1'b0;
    logic wb_we = 1'b0;
    logic [7:0] wb_adr = 8'h00;
    logic [31:0] wb_dat = 32'h0;
    logic [3:0] wb_sel = 4'hF;
    logic [3:0] wsel = 4'hF;
    logic idle_mode = 1'b0;
    logic [31:0] dout;
    logic ack;
    logic irq_out;
    logic [31:0] q;
    int errors = 0;
    int checks_done = 0;
    int cycles = 0;
    int d;
    int i;
    int n;

    crcfs_ctrl DUT (.mclk_in(mclk_in), .sys_rst_in(sys_rst_in),
        .wb_cyc_in(wb_cyc), .wb_stb_in(wb_stb), .wb_we_in(wb_we),
        .wb_adr_in(wb_adr), .wb_sel_in(wb_sel), .wb_dat_in(wb_dat),
        .wb_dat_out(dout), .wb_ack_out(ack), .idle_mode_in(idle_mode),
        .irq_out(irq_out));

    // Free-running 250 MHz clock.
    initial begin
        forever #2 mclk_in = ~mclk_in;
    end

    // Hang guard: the tests need well under two thousand cycles.
    always @(posedge mclk_in) begin
        cycles++;
        if (cycles == 20000) begin
            errors++;
            final_report();
        end
    end

    // Prints the verdict and ends the run.
    task final_report;
        if (errors == 0 && checks_done > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : final_report

    // Holds reset for 16 cycles.
    task rst;
        sys_rst_in <= 1'b1;
        repeat (16) @(posedge mclk_in);
        sys_rst_in <= 1'b0;
    endtask : rst

    // One classic bus cycle; read data lands in q at the ack edge.
    task xfer(input logic w, input logic [7:0] a, input logic [31:0] v);
        @(posedge mclk_in);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= w;
        wb_adr <= a;
        wb_dat <= v;
        wb_sel <= wsel;
        do @(posedge mclk_in); while (ack !== 1'b1);
        q = dout;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        wb_we <= 1'b0;
    endtask : xfer

    // Reads a register and compares it.
    task rchk(input logic [7:0] a, input logic [31:0] e, input string nm);
        xfer(1'b0, a, 32'h0);
        `CHK(nm, e, q)
    endtask : rchk

    // Reference 16-bit CRC step over one word, fixed polynomial.
    function automatic logic [31:0] crc_ref(input logic [31:0] c,
        input logic [15:0] w, input logic lsb);
        logic b;
        for (int k = 0; k < 16; k++) begin
            b = lsb ? w[k] : w[15-k];
            b = b ^ c[15];
            c = ((c << 1) ^ (b ? 32'h1021 : 32'h0)) & 32'hFFFF;
        end
        return c;
    endfunction : crc_ref

    // Main sequence.
    initial begin
        rst();
        rchk(crcfs_pkg::ADDR_CTRL, 32'h40, "ctrl_rst");
        rchk(crcfs_pkg::ADDR_POLYNOMIAL_LENGTH, 32'h0F, "polynomial_length_rst");
        rchk(crcfs_pkg::ADDR_INT_MASK, 32'h0, "mask_rst");
        xfer(1'b1, 8'h1C, 32'hFFFF_FFFF);
        rchk(8'h1C, 32'h0, "unmapped");
        // Byte enables merge a partial write into the polynomial.
        xfer(1'b1, crcfs_pkg::ADDR_POLY, 32'hFFFF_FFFF);
        wsel = 4'h2;
        xfer(1'b1, crcfs_pkg::ADDR_POLY, 32'h0);
        wsel = 4'hF;
        rchk(crcfs_pkg::ADDR_POLY, 32'hFFFF_00FF, "poly_sel");
        xfer(1'b1, crcfs_pkg::ADDR_CTRL, 32'h3FE8);
        rchk(crcfs_pkg::ADDR_CTRL, 32'h2068, "ctrl_rw");
        xfer(1'b1, crcfs_pkg::ADDR_CTRL, 32'h0);
        // Fill with the shifter stopped; long polynomial caps at 8.
        for (i = 1; i <= 9; i++) begin
            xfer(1'b1, crcfs_pkg::ADDR_DATA, i);
            rchk(crcfs_pkg::ADDR_CTRL, i >= 8 ? 32'h880 : i << 8, "fill");
        end
        xfer(1'b1, crcfs_pkg::ADDR_POLYNOMIAL_LENGTH, 32'h7);
        rchk(crcfs_pkg::ADDR_CTRL, 32'h800, "cap16");
        for (i = 9; i <= 16; i++) begin
            xfer(1'b1, crcfs_pkg::ADDR_DATA, i);
        end
        rchk(crcfs_pkg::ADDR_CTRL, 32'h1080, "full16");
        // Two words through the CRC, each direction and irq source.
        for (d = 0; d < 2; d++) begin
            rst();
            xfer(1'b1, crcfs_pkg::ADDR_POLY, 32'h1021);
            xfer(1'b1, crcfs_pkg::ADDR_RESULT, 32'hFFFF);
            xfer(1'b1, crcfs_pkg::ADDR_INT_MASK, 32'h3);
            xfer(1'b1, crcfs_pkg::ADDR_DATA, 32'h1234);
            xfer(1'b1, crcfs_pkg::ADDR_DATA, 32'hABCD);
            xfer(1'b1, crcfs_pkg::ADDR_CTRL, 32'h10 | d << 5 | d << 3);
            n = 0;
            while (irq_out !== 1'b1 && n < 300) begin
                @(posedge mclk_in);
                n++;
            end
            `CHK("irq_rise", 1'b1, irq_out)
            xfer(1'b0, crcfs_pkg::ADDR_CTRL, 32'h0);
            `CHK("go_at_irq", d, q[4])
            do xfer(1'b0, crcfs_pkg::ADDR_CTRL, 32'h0); while (q[4] !== 1'b0);
            `CHK("ctrl_done", 32'h40 | d << 5 | d << 3, q)
            rchk(crcfs_pkg::ADDR_INT_STAT, 32'h3, "status");
            q = crc_ref(crc_ref(32'hFFFF, 16'h1234, d[0]), 16'hABCD, d[0]);
            rchk(crcfs_pkg::ADDR_RESULT, q, "crc");
            repeat (2) @(posedge mclk_in);
            `CHK("irq_clear", 1'b0, irq_out)
        end
        // Stop in idle holds the queued word until idle ends.
        rst();
        idle_mode <= 1'b1;
        xfer(1'b1, crcfs_pkg::ADDR_DATA, 32'h5A5A);
        xfer(1'b1, crcfs_pkg::ADDR_CTRL, 32'h2010);
        repeat (40) @(posedge mclk_in);
        rchk(crcfs_pkg::ADDR_CTRL, 32'h2110, "halted");
        idle_mode <= 1'b0;
        do xfer(1'b0, crcfs_pkg::ADDR_CTRL, 32'h0); while (q[4] !== 1'b0);
        `CHK("resumed", 32'h2040, q)
        `CHK("irq_masked", 1'b0, irq_out)
        rchk(crcfs_pkg::ADDR_INT_STAT, 32'h3, "stat_masked");
        final_report();
    end
endmodule : tb_crcfs_ctrl
